// ===== design/light_conv_pkg.sv
package light_conv_pkg;

   // ==========================================================
   // timing
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned STEP_MS      = 100;
   localparam int unsigned STEP_CYCLES  = CLK_HZ / 1000 * STEP_MS;
   localparam int unsigned STEPS_MAX    = 6;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_PERSIST   = 8'h04;
   localparam logic [7:0] OFS_PERS_LO   = 8'h08;
   localparam logic [7:0] OFS_PERS_HI   = 8'h0C;
   localparam logic [7:0] OFS_IMM_LO    = 8'h10;
   localparam logic [7:0] OFS_IMM_HI    = 8'h14;
   localparam logic [7:0] OFS_RESULTS   = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;
   localparam logic [7:0] OFS_STATE     = 8'h24;

   // ==========================================================
   // control, result and interrupt fields
   localparam int unsigned CTRL_ACTIVE  = 0;
   localparam int unsigned CTRL_TIME_LO = 4;
   localparam int unsigned CTRL_GAIN_LO = 8;
   localparam int unsigned RES_IR_LO    = 16;
   localparam int unsigned IRQ_PERS     = 0;
   localparam int unsigned IRQ_IMM      = 1;
   localparam int unsigned IRQ_DONE     = 2;

   // ==========================================================
   // reset values and limits
   localparam logic [9:0]  CTRL_RESET   = 10'h000;
   localparam logic [3:0]  PERSIST_RST  = 4'h0;
   localparam logic [15:0] TH_LO_RESET  = 16'h0000;
   localparam logic [15:0] TH_HI_RESET  = 16'hFFFF;
   localparam logic [2:0]  IRQ_MASK_RST = 3'h0;
   localparam logic [2:0]  TIME_SHORT   = 3'h0;
   localparam logic [2:0]  TIME_LONGEST = 3'h5;
   localparam logic [15:0] SAT_SHORT    = 16'd36863;
   localparam logic [15:0] SAT_LONG     = 16'd65535;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_INTEG = 2'b01,
      ST_XFER  = 2'b10
   } conv_state_t;

endpackage : light_conv_pkg

// ===== design/threshold_src.sv
`timescale 1ns/1ps
module threshold_src
   import light_conv_pkg::*;
#(
   parameter int unsigned DW = 16,
   parameter int unsigned PW = 4
) (
   input  wire logic          pclk,      // system clock
   input  wire logic          presetn,   // async reset, active low
   input  wire logic          eval,      // one-cycle pulse: new result valid
   input  wire logic [DW-1:0] value,     // result to test
   input  wire logic [DW-1:0] lo_lim,    // lower limit
   input  wire logic [DW-1:0] hi_lim,    // upper limit
   input  wire logic [PW-1:0] need,      // consecutive hits needed, 0 = fire at once
   input  wire logic          clr,       // host cleared this source
   output logic               fire       // one-cycle pulse: source fires
);

   logic          out_range;
   logic [PW-1:0] hits_reg;

   // ==========================================================
   // window test
   assign out_range = (value > hi_lim) || (value < lo_lim);

   // consecutive out-of-range counter, saturates rather than wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hits_reg <= '0;
      end else if (clr) begin
         // a conversion landing on the clear still counts as the first of a new run
         hits_reg <= (eval && out_range) ? PW'(1) : '0;
      end else if (eval) begin
         if (!out_range) begin
            hits_reg <= '0;
         end else if (hits_reg != '1) begin
            hits_reg <= hits_reg + 1'b1;
         end
      end
   end

   // fires when this conversion completes the required run
   assign fire = eval && out_range && ((hits_reg + 1'b1) >= {1'b0, need});

endmodule : threshold_src

// ===== design/light_conv.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module light_conv
   import light_conv_pkg::*;
#(
   parameter int unsigned STEP_CYC = STEP_CYCLES   // cycles in one integration step
) (
   input  wire logic        pclk,       // system clock, 25 MHz
   input  wire logic        presetn,    // async reset, active low
   input  wire logic        psel,       // apb select
   input  wire logic        penable,    // apb access phase
   input  wire logic        pwrite,     // apb direction
   input  wire logic [7:0]  paddr,      // apb byte address
   input  wire logic [31:0] pwdata,     // apb write data
   output logic [31:0]      prdata,     // apb read data
   output logic             pready,     // apb ready
   output logic             pslverr,    // apb error, unmapped address
   input  wire logic        bb_pulse,   // broadband converter charge pulses (async)
   input  wire logic        ir_pulse,   // infrared converter charge pulses (async)
   output logic             int_o,      // interrupt pin output value, always low
   output logic             int_oe_n    // interrupt pin enable, low = pulling low
);

   // ==========================================================
   // registers
   logic [9:0]   ctrl_reg;
   logic [3:0]   persist_reg;
   logic [15:0]  pers_lo_reg, pers_hi_reg, imm_lo_reg, imm_hi_reg;
   logic [15:0]  bb_res_reg, ir_res_reg;
   logic [2:0]   irq_stat_reg, irq_mask_reg, irq_set;
   logic [31:0]  prdata_reg;
   logic         pready_reg, pslverr_reg, int_oe_n_reg;
   conv_state_t  state_reg;
   logic [22:0]  cyc_reg;
   logic [2:0]   step_reg, steps_need;
   logic [15:0]  bb_acc_reg, ir_acc_reg, sat_lim;
   logic [2:0]   bb_sync_reg, ir_sync_reg;
   logic         bb_edge, ir_edge, eval, fire_pers, fire_imm;
   logic         wr_acc, rd_acc, setup, stat_read, active;
   logic [2:0]   integ_sel;

   assign active    = ctrl_reg[CTRL_ACTIVE];
   assign integ_sel = ctrl_reg[CTRL_TIME_LO +: 3];

   // ==========================================================
   // apb slave (stands in for the two-wire host link)
   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pready_reg && pwrite;
   assign rd_acc = psel && penable && pready_reg && !pwrite;
   assign stat_read = rd_acc && (paddr == OFS_IRQ_STAT);

   // zero-wait slave: ready high from the first edge after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= 1'b1;
      end
   end

   // read data and error are prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (setup) begin
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         case (paddr)
            OFS_CTRL:     prdata_reg <= {22'h0, ctrl_reg};
            OFS_PERSIST:  prdata_reg <= {28'h0, persist_reg};
            OFS_PERS_LO:  prdata_reg <= {16'h0, pers_lo_reg};
            OFS_PERS_HI:  prdata_reg <= {16'h0, pers_hi_reg};
            OFS_IMM_LO:   prdata_reg <= {16'h0, imm_lo_reg};
            OFS_IMM_HI:   prdata_reg <= {16'h0, imm_hi_reg};
            // both channels in one word, so a pair is always coherent
            OFS_RESULTS:  prdata_reg <= {ir_res_reg, bb_res_reg};
            OFS_IRQ_STAT: prdata_reg <= {29'h0, irq_stat_reg};
            OFS_IRQ_MASK: prdata_reg <= {29'h0, irq_mask_reg};
            OFS_STATE:    prdata_reg <= {27'h0, step_reg, state_reg};
            default:      pslverr_reg <= 1'b1;
         endcase
      end
   end

   // control and threshold writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg     <= CTRL_RESET;
         persist_reg  <= PERSIST_RST;
         pers_lo_reg  <= TH_LO_RESET;
         pers_hi_reg  <= TH_HI_RESET;
         imm_lo_reg   <= TH_LO_RESET;
         imm_hi_reg   <= TH_HI_RESET;
         irq_mask_reg <= IRQ_MASK_RST;
      end else if (wr_acc) begin
         case (paddr)
            OFS_CTRL:     ctrl_reg     <= pwdata[9:0];
            OFS_PERSIST:  persist_reg  <= pwdata[3:0];
            OFS_PERS_LO:  pers_lo_reg  <= pwdata[15:0];
            OFS_PERS_HI:  pers_hi_reg  <= pwdata[15:0];
            OFS_IMM_LO:   imm_lo_reg   <= pwdata[15:0];
            OFS_IMM_HI:   imm_hi_reg   <= pwdata[15:0];
            OFS_IRQ_MASK: irq_mask_reg <= pwdata[2:0];
            default:      ;
         endcase
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // ==========================================================
   // pulse synchronisers: first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bb_sync_reg <= 3'h0;
         ir_sync_reg <= 3'h0;
      end else begin
         bb_sync_reg <= {bb_sync_reg[1:0], bb_pulse};
         ir_sync_reg <= {ir_sync_reg[1:0], ir_pulse};
      end
   end

   assign bb_edge = bb_sync_reg[1] && !bb_sync_reg[2];
   assign ir_edge = ir_sync_reg[1] && !ir_sync_reg[2];

   // ==========================================================
   // conversion sequencer
   // codes above 101b are clamped to the longest setting
   assign steps_need = (integ_sel > TIME_LONGEST) ? TIME_LONGEST : integ_sel;
   assign sat_lim    = (integ_sel == TIME_SHORT) ? SAT_SHORT : SAT_LONG;
   assign eval       = (state_reg == ST_XFER);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         cyc_reg   <= '0;
         step_reg  <= 3'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               cyc_reg  <= '0;
               step_reg <= 3'h0;
               if (active) begin
                  state_reg <= ST_INTEG;
               end
            end
            ST_INTEG: begin
               if (!active) begin
                  state_reg <= ST_IDLE;                 // abandon partial cycle on sleep
               end else if (cyc_reg == 23'(STEP_CYC - 1)) begin
                  cyc_reg <= '0;
                  if (step_reg >= steps_need) begin
                     state_reg <= ST_XFER;              // both channels stop together
                  end else begin
                     step_reg <= step_reg + 3'h1;
                  end
               end else begin
                  cyc_reg <= cyc_reg + 23'h1;
               end
            end
            ST_XFER: begin
               step_reg <= 3'h0;
               cyc_reg  <= '0;
               // restart with no host action, unless sleep was selected
               state_reg <= active ? ST_INTEG : ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // shared integrators, cleared together and counting together
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bb_acc_reg <= 16'h0000;
         ir_acc_reg <= 16'h0000;
      end else if (state_reg != ST_INTEG) begin
         bb_acc_reg <= 16'h0000;
         ir_acc_reg <= 16'h0000;
      end else begin
         // a shorter time picked mid-cycle pulls a count above the new ceiling down
         if (bb_edge && bb_acc_reg < sat_lim) begin
            bb_acc_reg <= bb_acc_reg + 16'h1;
         end else if (bb_acc_reg > sat_lim) begin
            bb_acc_reg <= sat_lim;
         end
         if (ir_edge && ir_acc_reg < sat_lim) begin
            ir_acc_reg <= ir_acc_reg + 16'h1;
         end else if (ir_acc_reg > sat_lim) begin
            ir_acc_reg <= sat_lim;
         end
      end
   end

   // result buffer loads only on transfer; sleep leaves it readable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bb_res_reg <= 16'h0000;
         ir_res_reg <= 16'h0000;
      end else if (eval) begin
         bb_res_reg <= bb_acc_reg;
         ir_res_reg <= ir_acc_reg;
      end
   end

   // ==========================================================
   // threshold sources, both watch the broadband result
   threshold_src #(.DW(16), .PW(4)) u_pers (
      .pclk    (pclk),
      .presetn (presetn),
      .eval    (eval),
      .value   (bb_acc_reg),
      .lo_lim  (pers_lo_reg),
      .hi_lim  (pers_hi_reg),
      .need    (persist_reg),
      .clr     (stat_read && prdata_reg[IRQ_PERS]),
      .fire    (fire_pers)
   );

   threshold_src #(.DW(16), .PW(4)) u_imm (
      .pclk    (pclk),
      .presetn (presetn),
      .eval    (eval),
      .value   (bb_acc_reg),
      .lo_lim  (imm_lo_reg),
      .hi_lim  (imm_hi_reg),
      .need    (4'h0),
      .clr     (stat_read && prdata_reg[IRQ_IMM]),
      .fire    (fire_imm)
   );

   // ==========================================================
   // interrupt status: sticky, read clears, a new event wins over the clear
   assign irq_set = {eval, fire_imm, fire_pers};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= 3'h0;
      end else if (stat_read) begin
         // clear only what the read returned: an event landing on the setup
         // edge is not in the snapshot and must not be lost
         irq_stat_reg <= (irq_stat_reg & ~prdata_reg[2:0]) | irq_set;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_set;
      end
   end

   // open-drain pin: value is always low, only the enable moves
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_oe_n_reg <= 1'b1;
      end else begin
         int_oe_n_reg <= ~|(irq_stat_reg & irq_mask_reg);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_o <= 1'b0;
      end else begin
         int_o <= 1'b0;
      end
   end

   assign int_oe_n = int_oe_n_reg;

   // ==========================================================
   // assertions
   a_both_cleared: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_XFER) |=> (bb_acc_reg == 16'h0000 && ir_acc_reg == 16'h0000))
      else $error("integrators not cleared together");

   a_result_load: assert property (@(posedge pclk) disable iff (!presetn)
      eval |=> (bb_res_reg == $past(bb_acc_reg) && ir_res_reg == $past(ir_acc_reg)))
      else $error("results not loaded from integrators");

   a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !eval |=> ($stable(bb_res_reg) && $stable(ir_res_reg)))
      else $error("results moved outside a transfer");

   a_auto_restart: assert property (@(posedge pclk) disable iff (!presetn)
      (eval && active) |=> (state_reg == ST_INTEG && cyc_reg == 23'h0))
      else $error("no automatic restart after transfer");

   a_irq_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_stat_reg[IRQ_IMM] && !stat_read) |=> irq_stat_reg[IRQ_IMM])
      else $error("status bit dropped without a clear");

   a_pin_pulls: assert property (@(posedge pclk) disable iff (!presetn)
      (|(irq_stat_reg & irq_mask_reg)) |=> (!int_oe_n && !int_o))
      else $error("pending interrupt not driven low");

   a_pin_release: assert property (@(posedge pclk) disable iff (!presetn)
      !(|(irq_stat_reg & irq_mask_reg)) |=> int_oe_n)
      else $error("pin driven with nothing pending");

   a_imm_fires: assert property (@(posedge pclk) disable iff (!presetn)
      (eval && (bb_acc_reg > imm_hi_reg || bb_acc_reg < imm_lo_reg))
      |=> irq_stat_reg[IRQ_IMM])
      else $error("immediate source missed an out-of-range result");

   a_sat_short: assert property (@(posedge pclk) disable iff (!presetn)
      (integ_sel == TIME_SHORT) |=> (bb_acc_reg <= SAT_SHORT && ir_acc_reg <= SAT_SHORT))
      else $error("short setting count above its ceiling");

   a_sleep_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !active |=> (state_reg == ST_IDLE))
      else $error("integration started while asleep");

   a_xfer_once: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_XFER) |=> (state_reg != ST_XFER))
      else $error("transfer state held for more than one cycle");

   a_integ_len: assert property (@(posedge pclk) disable iff (!presetn)
      eval |-> ($past(cyc_reg) == 23'(STEP_CYC - 1)))
      else $error("transfer before the end of an integration step");

   a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
      eval |=> irq_stat_reg[IRQ_DONE])
      else $error("transfer did not flag conversion done");

   a_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (stat_read && !eval) |=> ((irq_stat_reg & prdata_reg[2:0]) == 3'h0))
      else $error("status bits survived the read that returned them");

   a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && paddr[1:0] == 2'b00 && paddr <= OFS_STATE) |=> !pslverr)
      else $error("error flagged on a mapped register");

   a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && paddr > OFS_STATE) |=> pslverr)
      else $error("unmapped register accepted without error");

   c_transfer:  cover property (@(posedge pclk) disable iff (!presetn) eval ##1 active);
   c_pers_fire: cover property (@(posedge pclk) disable iff (!presetn) fire_pers);
   c_imm_fire:  cover property (@(posedge pclk) disable iff (!presetn) fire_imm ##1 !int_oe_n);
   c_sleep:     cover property (@(posedge pclk) disable iff (!presetn)
      (state_reg == ST_INTEG) ##1 (state_reg == ST_IDLE));
   c_pers_clr:  cover property (@(posedge pclk) disable iff (!presetn)
      stat_read && prdata_reg[IRQ_PERS]);

endmodule : light_conv

// ===== testbench/light_pulse_src.sv
`timescale 1ns/1ps
// ==========================================
// light front end and interrupt wire model
module light_pulse_src (
   input  wire logic       pclk,     // system clock
   input  wire logic       presetn,  // async reset, active low
   input  wire logic [7:0] bb_per,   // cycles between broadband pulses
   input  wire logic [7:0] ir_per,   // cycles between infrared pulses
   input  wire logic       int_o,    // pin value from the block
   input  wire logic       int_oe_n, // pin enable, low = block pulls low
   output logic            bb_pulse, // broadband charge pulses
   output logic            ir_pulse, // infrared charge pulses
   output logic            int_line  // resolved interrupt wire
);
   logic [7:0] bb_cnt;
   logic [7:0] ir_cnt;

   // steady light: a fixed rate means any window that is a multiple of the
   // period holds exactly window/period rising edges, whatever the phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bb_cnt <= 8'h00;
         ir_cnt <= 8'h00;
      end else begin
         bb_cnt <= (bb_cnt + 8'h01 >= bb_per) ? 8'h00 : bb_cnt + 8'h01;
         ir_cnt <= (ir_cnt + 8'h01 >= ir_per) ? 8'h00 : ir_cnt + 8'h01;
      end
   end

   // pulses stay high half a period so the synchroniser cannot miss them
   assign bb_pulse = (bb_cnt < (bb_per >> 1));
   assign ir_pulse = (ir_cnt < (ir_per >> 1));

   // board pull-up: the line reads high whenever the pin is released
   assign int_line = int_oe_n ? 1'b1 : int_o;
endmodule : light_pulse_src

// ===== testbench/light_conv_tb.sv
`timescale 1ns/1ps
module light_conv_tb
   import light_conv_pkg::*;
;
   // short step keeps every conversion between 21 and 121 cycles long
   localparam int unsigned STEP   = 20;
   localparam int unsigned BB_PER = 4;
   localparam int unsigned IR_PER = 5;

   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, ctrl, exp_res;
   logic        pready, pslverr, err, bb_pulse, ir_pulse, int_o, int_oe_n, int_line;
   int          num_errors, n_compared, cyc, t0, t1, k, n, hits;
   int          tsel [7] = '{0, 1, 2, 3, 4, 5, 7};
   logic [7:0]  ra [10] = '{OFS_CTRL, OFS_PERSIST, OFS_PERS_LO, OFS_PERS_HI, OFS_IMM_LO,
                            OFS_IMM_HI, OFS_RESULTS, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_STATE};
   logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'hffff, 32'h0, 32'hffff,
                            32'h0, 32'h0, 32'h0, 32'h0};
   logic [15:0] phi [12] = '{16'h2, 16'h2, 16'h2, 16'h2, 16'h2, 16'h2, 16'h2,
                             16'hffff, 16'h2, 16'h2, 16'h2, 16'h2};
   logic [31:0] pexp [12] = '{32'h6, 32'h6, 32'h7, 32'h6, 32'h6, 32'h7,
                              32'h6, 32'h6, 32'h6, 32'h6, 32'h6, 32'h7};

   // ==========================================
   // clock, cycle count, instances
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk) cyc <= cyc + 1;

   light_conv #(.STEP_CYC(STEP)) i_light_conv (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bb_pulse(bb_pulse),
      .ir_pulse(ir_pulse), .int_o(int_o), .int_oe_n(int_oe_n));

   light_pulse_src i_light_pulse_src (
      .pclk(pclk), .presetn(presetn), .bb_per(8'(BB_PER)), .ir_per(8'(IR_PER)),
      .int_o(int_o), .int_oe_n(int_oe_n), .bb_pulse(bb_pulse),
      .ir_pulse(ir_pulse), .int_line(int_line));

   // ==========================================
   // checking and closing
   task check(input logic [31:0] seen, input logic [31:0] expv, input string what);
      n_compared++;
      if (seen !== expv) begin
         num_errors++;
         $display("mismatch %s: expected %h, seen %h", what, expv, seen);
      end
   endtask : check

   task test_done;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // ==========================================
   // bus and interrupt tasks
   // one apb transfer; the request holds until pready is seen high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int w;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 50);
      if (w >= 50) begin
         num_errors++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // two edges first: the line is released one cycle after a clearing read
   task wait_irq;
      int w;
      w = 0;
      repeat (2) @(posedge pclk);
      while (int_line !== 1'b0 && w < 2000) begin
         @(posedge pclk);
         w++;
      end
      if (w >= 2000) begin
         num_errors++;
         test_done();
      end
      t1 = cyc;
   endtask : wait_irq

   // wait for an event, then read the status, which clears it
   task next_done;
      wait_irq();
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
   endtask : next_done

   // ==========================================
   // main sequence
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      cyc = 0;
      num_errors = 0;
      n_compared = 0;
      repeat (16) @(posedge pclk);
      check(32'(int_line), 32'h1, "line in reset");
      presetn <= 1'b1;
      for (k = 0; k < 10; k++) begin
         apb(1'b0, ra[k], 32'h0);
         check(rd, rv[k], "reset value");
      end
      apb(1'b0, 8'h28, 32'h0);
      check({rd[30:0], err}, 32'h1, "unmapped read");
      apb(1'b1, 8'h28, 32'h1);
      check(32'(err), 32'h1, "unmapped write");
      // every time code but 6, gain codes along the way; first event may be mixed
      apb(1'b1, OFS_IRQ_MASK, 32'h4);
      for (k = 0; k < 7; k++) begin
         n = (tsel[k] > 5) ? 6 : tsel[k] + 1;
         ctrl = 32'(1 + (tsel[k] << 4) + ((k % 4) << 8));
         apb(1'b1, OFS_CTRL, ctrl);
         apb(1'b0, OFS_CTRL, 32'h0);
         check(rd, ctrl, "control readback");
         apb(1'b0, OFS_IRQ_STAT, 32'h0);
         next_done();
         next_done();
         t0 = t1;
         next_done();
         check(32'(rd[IRQ_DONE]), 32'h1, "done status");
         check(32'(t1 - t0), 32'(STEP * n + 1), "conversion period");
         exp_res = {16'(STEP * n / IR_PER), 16'(STEP * n / BB_PER)};
         apb(1'b0, OFS_RESULTS, 32'h0);
         check(rd, exp_res, "results");
         apb(1'b1, OFS_RESULTS, 32'hdead_beef);
         apb(1'b0, OFS_RESULTS, 32'h0);
         check(rd, exp_res, "results after write");
      end
      // masked events set status but leave the line alone
      apb(1'b1, OFS_IRQ_MASK, 32'h0);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      hits = 0;
      repeat (150) begin
         @(posedge pclk);
         if (int_line !== 1'b1) hits++;
      end
      check(32'(hits), 32'h0, "masked line");
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      check(32'(rd[IRQ_DONE]), 32'h1, "masked status");
      apb(1'b1, OFS_IRQ_MASK, 32'h4);
      wait_irq();
      repeat (30) @(posedge pclk);
      check(32'(int_line), 32'h0, "held line");
      check(32'(int_o), 32'h0, "pin value");
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      repeat (2) @(posedge pclk);
      check(32'(int_line), 32'h1, "released line");
      // sleep: no new cycles, last results stay readable
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b0, OFS_STATE, 32'h0);
      check(32'(rd[1:0]), 32'h0, "state asleep");
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      repeat (200) @(posedge pclk);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      check(rd, 32'h0, "events asleep");
      apb(1'b0, OFS_RESULTS, 32'h0);
      check(rd, exp_res, "results kept");
      // broadband count 5: below the immediate floor, above the persistence ceiling
      apb(1'b1, OFS_PERSIST, 32'h3);
      apb(1'b1, OFS_IMM_LO, 32'h6);
      apb(1'b1, OFS_PERS_HI, 32'h2);
      apb(1'b1, OFS_IRQ_MASK, 32'h7);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h1);
      for (k = 0; k < 12; k++) begin
         next_done();
         check(rd, pexp[k], "threshold status");
         apb(1'b1, OFS_PERS_HI, {16'h0, phi[k]});
      end
      test_done();
   end
endmodule : light_conv_tb
